/* File: tsa_top.sv */
module tsa_top #(
   parameter int TICK_CYCLES = tsa_pkg::TICK_CYC_DEFAULT
) (
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic [tsa_pkg::TRIPS-1:0]  trip_cond,
   input  wire logic [tsa_pkg::CAUSES-1:0] other_cause,
   input  wire logic [tsa_pkg::BOARDS-1:0] board_ok,
   input  wire logic                       start_input,
   input  wire logic                       clear_key,
   input  wire tsa_pkg::tsa_wb_req_t       wb_req,
   output logic [31:0]                     wb_dat_o,
   output logic                            wb_ack_o,
   output logic                            healthy,
   output logic [tsa_pkg::BOARDS-1:0]      board_led,
   output logic                            irq
);

   tsa_pkg::tsa_st_t                st_r;
   tsa_pkg::tsa_st_t                st_nxt;
   logic [tsa_pkg::TRIPS-1:0]       cond;
   logic [tsa_pkg::TRIPS-1:0]       qual;
   logic [tsa_pkg::BOARDS-1:0]      board;

   // ****************************************************************
   // condition assembly
   // ****************************************************************
   assign board = st_r.filt[tsa_pkg::P_BOARD_LSB +: tsa_pkg::BOARDS];

   always_comb
   begin
      cond = st_r.filt[tsa_pkg::P_TRIP_LSB +: tsa_pkg::TRIPS];
      // board lines are healthy-high, so a low line 2..5 is a fault; lines 0 and 1 raise no trip
      cond[tsa_pkg::T_HEATSINK] = cond[tsa_pkg::T_HEATSINK]
                                 | ~board[tsa_pkg::B_FIELD_SINK_OK]
                                 | ~board[tsa_pkg::B_STACK_TEMP_OK];
      cond[tsa_pkg::T_PHASE_LOSS] = cond[tsa_pkg::T_PHASE_LOSS]
                                   | ~board[tsa_pkg::B_FUSES_OK];
      cond[tsa_pkg::T_CT_LOSS] = cond[tsa_pkg::T_CT_LOSS]
                                | ~board[tsa_pkg::B_CT_DETECTED];
   end

   // ****************************************************************
   // per-trip delay qualifiers
   // ****************************************************************
   generate
      for (genvar i = 0; i < tsa_pkg::TRIPS; i++)
      begin : g_qual
         tsa_qual u_qual (
            .clk      (clk),
            .reset_n  (reset_n),
            .tick     (st_r.tick),
            .cond     (cond[i]),
            .limit_ms (tsa_pkg::DELAY_MS[i]),
            .qual     (qual[i])
         );
      end
   endgenerate

   // ****************************************************************
   // next state
   // ****************************************************************
   logic [15:0]  newly;
   logic [15:0]  lowest;
   logic [15:0]  code;
   logic         start_edge;
   logic         clear_edge;
   logic         req;
   logic         wr;
   logic [31:0]  rdat;
   logic         reset_ok;

   always_comb
   begin
      st_nxt = st_r;

      // three-stage pin synchroniser, change taken when stages 2 and 3 agree
      st_nxt.s1 = {clear_key, start_input, board_ok, other_cause, trip_cond};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int b = 0; b < tsa_pkg::P_W; b++)
      begin
         if (st_r.s2[b] == st_r.s3[b])
            st_nxt.filt[b] = st_r.s3[b];
      end

      // millisecond tick for the delay qualifiers
      st_nxt.tick = 1'b0;
      if (st_r.tick_cnt >= 15'(TICK_CYCLES - 1))
      begin
         st_nxt.tick_cnt = 15'h0000;
         st_nxt.tick     = 1'b1;
      end
      else
         st_nxt.tick_cnt = st_r.tick_cnt + 15'h0001;

      st_nxt.start_d = st_r.filt[tsa_pkg::P_START];
      st_nxt.clear_d = st_r.filt[tsa_pkg::P_CLEAR];
      start_edge = st_r.filt[tsa_pkg::P_START] & ~st_r.start_d;
      clear_edge = st_r.filt[tsa_pkg::P_CLEAR] & ~st_r.clear_d;

      // bus decode
      req  = wb_req.cyc & wb_req.stb & ~st_r.ack;
      wr   = req & wb_req.we;

      // trips newly qualified this cycle; lowest index wins a tie
      newly  = qual & ~st_r.active;
      lowest = newly & (~newly + 16'h0001);
      code   = lowest;
      if (lowest[tsa_pkg::T_OTHER])
         code = tsa_pkg::EXT_CODE[st_r.filt[tsa_pkg::P_CAUSE_LSB +: tsa_pkg::CAUSES]];

      // reset of the trip word only with no raw condition left
      reset_ok = start_edge & (cond == tsa_pkg::TRIP_NONE) & (qual == tsa_pkg::TRIP_NONE);
      if (reset_ok)
         st_nxt.active = tsa_pkg::TRIP_NONE;
      // codes are disjoint bits, so or is the sum; a set beats the clear
      st_nxt.active = st_nxt.active | qual;

      if (start_edge)
         st_nxt.first = tsa_pkg::TRIP_NONE;
      if ((st_nxt.first == tsa_pkg::TRIP_NONE) && (lowest != tsa_pkg::TRIP_NONE))
         st_nxt.first = lowest;

      if (clear_edge || (wr && wb_req.adr == tsa_pkg::A_CTRL && wb_req.sel[0]
                          && wb_req.dat[tsa_pkg::CTRL_CLEAR]))
         st_nxt.latest = tsa_pkg::NO_ALARM;
      if (lowest != tsa_pkg::TRIP_NONE)
         st_nxt.latest = code;

      // alarm indication toward the panel
      st_nxt.healthy = (st_nxt.active == tsa_pkg::TRIP_NONE);
      st_nxt.led     = board;

      // interrupt status, write one to clear; events win over the clear
      if (wr && wb_req.adr == tsa_pkg::A_IRQ_ST && wb_req.sel[0])
         st_nxt.irq_st = st_r.irq_st & ~wb_req.dat[tsa_pkg::IRQ_W-1:0];
      if (wr && wb_req.adr == tsa_pkg::A_IRQ_MSK && wb_req.sel[0])
         st_nxt.irq_msk = wb_req.dat[tsa_pkg::IRQ_W-1:0];
      if (lowest != tsa_pkg::TRIP_NONE)
         st_nxt.irq_st[tsa_pkg::IRQ_NEW] = 1'b1;
      if (reset_ok && st_r.active != tsa_pkg::TRIP_NONE)
         st_nxt.irq_st[tsa_pkg::IRQ_CLEARED] = 1'b1;
      st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_msk);

      // read mux; unmapped addresses read zero and still ack
      case (wb_req.adr)
         tsa_pkg::A_ACTIVE  : rdat = {16'h0000, st_r.active};
         tsa_pkg::A_FIRST   : rdat = {16'h0000, st_r.first};
         tsa_pkg::A_LATEST  : rdat = {16'h0000, st_r.latest};
         tsa_pkg::A_IRQ_ST  : rdat = {30'h00000000, st_r.irq_st};
         tsa_pkg::A_IRQ_MSK : rdat = {30'h00000000, st_r.irq_msk};
         tsa_pkg::A_BOARD   : rdat = {26'h0000000, board};
         default            : rdat = 32'h00000000;
      endcase
      st_nxt.ack = req;
      st_nxt.dat = req ? rdat : 32'h00000000;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // a power cycle clears every trip word and the latest alarm
         st_r         <= '0;
         st_r.healthy <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign wb_dat_o  = st_r.dat;
   assign wb_ack_o  = st_r.ack;
   assign healthy   = st_r.healthy;
   assign board_led = st_r.led;
   assign irq       = st_r.irq;

endmodule

/* File: tsa_qual.sv */
// ****************************************************************
// shared constants and types
// ****************************************************************
package tsa_pkg;

   localparam int CLK_HZ           = 20_000_000;
   localparam int TICK_MS          = 1;
   // cycles of one delay tick, derived from the clock rate
   localparam int TICK_CYC_DEFAULT = CLK_HZ / 1000 * TICK_MS;

   localparam int TRIPS  = 16;
   localparam int CAUSES = 3;
   localparam int BOARDS = 6;

   // trip bit positions
   localparam int T_SPEED_EXCESS   = 0;
   localparam int T_PULSE_LOSS     = 1;
   localparam int T_FIELD_OVERCUR  = 2;
   localparam int T_HEATSINK       = 3;
   localparam int T_PHASE_LOSS     = 9;
   localparam int T_OTHER          = 14;
   localparam int T_CT_LOSS        = 15;

   // board status bit positions (high = healthy)
   localparam int B_AUX_SUPPLY     = 0;
   localparam int B_TRIGGER_BOARD  = 1;
   localparam int B_CT_DETECTED    = 2;
   localparam int B_FUSES_OK       = 3;
   localparam int B_FIELD_SINK_OK  = 4;
   localparam int B_STACK_TEMP_OK  = 5;

   // synchronised pin vector layout
   localparam int P_TRIP_LSB  = 0;
   localparam int P_CAUSE_LSB = 16;
   localparam int P_BOARD_LSB = 19;
   localparam int P_START     = 25;
   localparam int P_CLEAR     = 26;
   localparam int P_W         = 27;

   // per-trip qualifying delay in ms, index = trip number
   localparam logic [TRIPS-1:0][15:0] DELAY_MS = {
      16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064,
      16'h0064, 16'h0064, 16'h0064, 16'h3a98, 16'h02ee, 16'h3a98, 16'hea60, 16'h0064};

   // extended codes of the generic other trip, index = cause
   localparam logic [7:0][15:0] EXT_CODE = {
      16'hff06, 16'hff05, 16'hf400, 16'hf200, 16'hf006, 16'hf005, 16'hf002, 16'hf001};

   localparam logic [15:0] NO_ALARM  = 16'h0000;
   localparam logic [15:0] TRIP_NONE = 16'h0000;

   // register byte offsets
   localparam logic [7:0] A_ACTIVE  = 8'h00;
   localparam logic [7:0] A_FIRST   = 8'h04;
   localparam logic [7:0] A_LATEST  = 8'h08;
   localparam logic [7:0] A_IRQ_ST  = 8'h0c;
   localparam logic [7:0] A_IRQ_MSK = 8'h10;
   localparam logic [7:0] A_CTRL    = 8'h14;
   localparam logic [7:0] A_BOARD   = 8'h18;

   localparam int IRQ_W       = 2;
   localparam int IRQ_NEW     = 0;
   localparam int IRQ_CLEARED = 1;
   localparam int CTRL_CLEAR  = 0;

   typedef struct packed {
      logic [15:0] cnt;
      logic        q;
   } tsa_qual_st_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } tsa_wb_req_t;

   typedef struct packed {
      logic [P_W-1:0]   s1;
      logic [P_W-1:0]   s2;
      logic [P_W-1:0]   s3;
      logic [P_W-1:0]   filt;
      logic [14:0]      tick_cnt;
      logic             tick;
      logic             start_d;
      logic             clear_d;
      logic [15:0]      active;
      logic [15:0]      first;
      logic [15:0]      latest;
      logic [IRQ_W-1:0] irq_st;
      logic [IRQ_W-1:0] irq_msk;
      logic             irq;
      logic             ack;
      logic [31:0]      dat;
      logic             healthy;
      logic [BOARDS-1:0] led;
   } tsa_st_t;

endpackage

// ****************************************************************
// one trip delay qualifier
// ****************************************************************
module tsa_qual (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        tick,
   input  wire logic        cond,
   input  wire logic [15:0] limit_ms,
   output logic             qual
);

   tsa_pkg::tsa_qual_st_t st_r;
   tsa_pkg::tsa_qual_st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (!cond)
      begin
         // any drop restarts the whole delay
         st_nxt.cnt = 16'h0000;
         st_nxt.q   = 1'b0;
      end
      else if (st_r.cnt >= limit_ms)
         st_nxt.q = 1'b1;
      else if (tick)
         st_nxt.cnt = st_r.cnt + 16'h0001;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign qual = st_r.q;

endmodule

/* File: tsa_top_asserts.sv */
// ****
// port checks of the trip aggregator
// ****
module tsa_top_asserts #(
   parameter int TICK_CYCLES = 2
) (
   input wire logic                 clk,
   input wire logic                 reset_n,
   input wire logic [15:0]          trip_cond,
   input wire logic [5:0]           board_ok,
   input wire logic                 start_input,
   input wire tsa_pkg::tsa_wb_req_t wb_req,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   input wire logic                 healthy,
   input wire logic [5:0]           board_led
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [31:0] held_r;
   logic        any_cond;
   // board lines 2..5 feed trips, 0 and 1 only reach the lamps and the board register
   assign any_cond = (trip_cond != 16'h0) || (board_ok[5:2] != 4'hf);
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         held_r <= 32'h0;
      else
         held_r <= any_cond ? held_r + 32'h1 : 32'h0;
   sequence bus_req;
      wb_req.cyc && wb_req.stb && !wb_ack_o;
   endsequence
   sequence steady_trip;
      trip_cond != 16'h0 && $stable(trip_cond) && !healthy;
   endsequence
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_answer_a: assert property (bus_req |=> wb_ack_o) else $error("request not answered");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_req.cyc && wb_req.stb)) else $error("stray ack");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
   trip_qual_a:
      assert property ($fell(healthy) |-> held_r >= 99 * TICK_CYCLES) else $error("trip too early");
   heal_rise_a: assert property ($rose(healthy) |-> $past(start_input)) else $error("healthy without start");
   trip_hold_a: assert property (steady_trip [*6] |=> !healthy) else $error("reset with trip present");
   led_follow_a:
      assert property ($stable(board_ok) [*8] |-> board_led == board_ok) else $error("lamp mismatch");
endmodule
bind tsa_top tsa_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk(clk), .reset_n(reset_n),
   .trip_cond(trip_cond), .board_ok(board_ok), .start_input(start_input), .wb_req(wb_req),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .healthy(healthy), .board_led(board_led));

/* File: tsa_panel.sv */
// ****
// operator panel and start input
// ****
module tsa_panel (
   input  wire logic clk,
   input  wire logic start_req,
   input  wire logic clear_req,
   output logic      start_input,
   output logic      clear_key
);
   timeunit 1ns;
   timeprecision 1ns;
   int start_cnt = 0;
   int clear_cnt = 0;
   // keys held well past the input filter, as a hand would
   always @(posedge clk)
   begin
      start_cnt <= start_req ? 16 : (start_cnt > 0 ? start_cnt - 1 : 0);
      clear_cnt <= clear_req ? 16 : (clear_cnt > 0 ? clear_cnt - 1 : 0);
   end
   assign start_input = start_cnt > 0;
   assign clear_key = clear_cnt > 0;
endmodule

/* File: test_trip_status_aggregator.sv */
// ****
// bench
// ****
module test_trip_status_aggregator;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk = 1'b0;
   logic                 reset_n = 1'b0;
   logic [15:0]          trip_cond = 16'h0;
   logic [2:0]           other_cause = 3'h0;
   logic [5:0]           board_ok = 6'h3f;
   logic                 start_req = 1'b0;
   logic                 clear_req = 1'b0;
   logic                 start_input, clear_key, wb_ack_o, healthy, irq;
   logic [31:0]          wb_dat_o, rdat;
   logic [5:0]           board_led;
   tsa_pkg::tsa_wb_req_t wb_req = '0;
   int                   err_total = 0;
   int                   comparisons = 0;
   int                   cycles = 0;
   logic [15:0] ext [8] = '{16'hf001, 16'hf002, 16'hf005, 16'hf006, 16'hf200, 16'hf400, 16'hff05, 16'hff06};
   logic [5:0]  bmask [4] = '{6'h2f, 6'h1f, 6'h37, 6'h3b};
   logic [15:0] bexp [4] = '{16'h0008, 16'h0008, 16'h0200, 16'h8000};
   always #25 clk = ~clk;
   tsa_panel i_panel (.clk(clk), .start_req(start_req), .clear_req(clear_req),
      .start_input(start_input), .clear_key(clear_key));
   tsa_top #(.TICK_CYCLES(2)) i_dut (.clk(clk), .reset_n(reset_n), .trip_cond(trip_cond),
      .other_cause(other_cause), .board_ok(board_ok), .start_input(start_input), .clear_key(clear_key),
      .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .healthy(healthy),
      .board_led(board_led), .irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // no fixed answer time assumed, the loop bound only catches a hang
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n = 0;
      @(posedge clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      rdat = wb_dat_o;
      wb_req <= '0;
      if (n >= 20)
         chk(32'h1, 32'h0);
   endtask
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic wait_h(input logic v);
      int n = 0;
      while (healthy !== v && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, healthy}, {31'h0, v});
      repeat (2) @(posedge clk);
   endtask
   task automatic press(input logic s);
      start_req <= s;
      clear_req <= !s;
      @(posedge clk);
      start_req <= 1'b0;
      clear_req <= 1'b0;
      repeat (24) @(posedge clk);
   endtask
   task automatic calm;
      trip_cond <= 16'h0;
      board_ok <= 6'h3f;
      repeat (10) @(posedge clk);
      press(1'b1);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         err_total++;
         conclude;
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h00, 32'h0);
      rd(8'h08, 32'h0);
      rd(8'h1c, 32'h0);
      trip_cond <= 16'h0001;
      repeat (150) @(posedge clk);
      trip_cond <= 16'h0;
      repeat (10) @(posedge clk);
      chk({31'h0, healthy}, 32'h1);
      trip_cond <= 16'h0001;
      wait_h(1'b0);
      trip_cond <= 16'h0021;
      repeat (220) @(posedge clk);
      wr_ro: bus(1'b1, 8'h00, 32'hffff);
      rd(8'h00, 32'h21);
      rd(8'h04, 32'h1);
      rd(8'h08, 32'h20);
      rd(8'h0c, 32'h1);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 8'h10, 32'h1);
      rd(8'h10, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, 8'h0c, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      press(1'b1);
      rd(8'h00, 32'h21);
      chk({31'h0, healthy}, 32'h0);
      rd(8'h04, 32'h0);
      calm;
      rd(8'h00, 32'h0);
      rd(8'h0c, 32'h2);
      rd(8'h08, 32'h20);
      press(1'b0);
      rd(8'h08, 32'h0);
      for (int c = 0; c < 8; c++)
      begin
         other_cause <= 3'(c);
         trip_cond <= 16'h4000;
         wait_h(1'b0);
         rd(8'h08, {16'h0, ext[c]});
         rd(8'h00, 32'h4000);
         calm;
      end
      bus(1'b1, 8'h14, 32'h1);
      rd(8'h08, 32'h0);
      for (int b = 0; b < 4; b++)
      begin
         board_ok <= bmask[b];
         wait_h(1'b0);
         chk({26'h0, board_led}, {26'h0, bmask[b]});
         rd(8'h00, {16'h0, bexp[b]});
         rd(8'h18, {26'h0, bmask[b]});
         calm;
      end
      rd(8'h08, 32'h8000);
      // a power cycle in mid-run must wipe the latest alarm
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h08, 32'h0);
      conclude;
   end
endmodule
